// File: hw/pulse_dialer_with_redial.sv
/*
 * Pulse dialer with 32-digit redial memory: keypad scan and debounce,
 * digit store, outpulsing with mute and acknowledgement tone.
 * Assumes all pins are synchronous to core_clk; open-drain pins and
 * the key lines are resolved outside from the o/oe pairs.
 */
// Summary of operation
// RL1 - Pulse rate 10 pps low, 20 pps high
// RL2 - 20 pps halves debounce, pauses, mute overlap
// RL3 - All intervals counted in oscillator ticks
// RL4 - Key accepted after 10 ms stable
// RL5 - User holds key at least 40 ms
// RL6 - Rollover key held 5 ms after release
// RL7 - Valid key: one row with one column
// RL8 - On-hook holds key lines high, ignores keys
// RL9 - Static keypad, oscillator off until key sensed
// RL10 - On-hook 300 ms clears memory state
// RL11 - Mute held 5 ms after last pulse
// RL12 - Start-up plus debounce within 40 ms
// RL13 - Tone 1 kHz or 2 kHz while held
// RL14 - 800 ms pause before and between digits
// RL15 - Digit value gives break count, zero ten
// RL16 - Ratio select: 34/66 high, 40/60 low
// RL17 - Mute from pre-digit pause past last break
// RL18 - Pulse pin open on make, low on break
// RL19 - On-hook while dialing: 100x rate, 50/50
`timescale 1ns/1ps
module pulse_dialer_with_redial
    import dialer_pkg::*;
#(
    parameter int unsigned OSC_DIV = OSC_DIV_DEF // Core cycles per tick
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Straps and hook
    input wire logic hook_in,
    input wire logic rate_select_in,
    input wire logic ratio_select_in,
    // Keypad rows
    input wire logic [3:0] row_i,
    output logic [3:0] row_o,
    output logic [3:0] row_oe,
    // Keypad columns
    input wire logic [2:0] col_i,
    output logic [2:0] col_o,
    output logic [2:0] col_oe,
    // Line pulse, mute, tone
    output logic pulse_o,
    output logic pulse_oe,
    output logic mute_o,
    output logic mute_oe,
    output logic tone_out
);

    dial_state_t st_q; // Whole registered state
    dial_state_t st_d; // Next state
    logic osc_run; // Oscillator enabled
    logic tick; // One oscillator period elapsed
    logic kv; // Decoded key valid
    logic [3:0] kc; // Decoded key code

    // Halve at 20 pps, never below one tick
    function automatic logic [11:0] scale(input logic [11:0] x,
                                          input logic r20);
        if (r20 && x > 12'h001)
            scale = x >> 1; // RL2
        else
            scale = x;
    endfunction : scale

    // Break length for one pulse
    function automatic logic [11:0] brk_len(input logic f,
                                            input logic r20,
                                            input logic ratio);
        if (f)
            brk_len = scale(FAST_HALF, r20); // RL19
        else
            brk_len = scale(ratio ? BRK66_TICKS : BRK60_TICKS, r20);
    endfunction : brk_len

    // Make length for one pulse
    function automatic logic [11:0] mk_len(input logic f,
                                           input logic r20,
                                           input logic ratio);
        if (f)
            mk_len = scale(FAST_HALF, r20); // RL19
        else
            mk_len = scale(ratio ? MAKE34_TICKS : MAKE40_TICKS, r20); // RL16
    endfunction : mk_len

    // Scan result decoder
    key_decode u_dec (
        .row_lo(~row_i),
        .col_lo(st_q.col_cap),
        .valid(kv),
        .code(kc)
    );

    // Oscillator runs only while scanning, dialing or timing the hook
    always_comb
    begin
        osc_run = (st_q.kst == K_SCAN) || (st_q.kst == K_HELD) ||
                  (st_q.dst != D_IDLE) ||
                  (st_q.kst == K_OFF && hook_in && !st_q.cleared); // RL9
        tick = osc_run && (st_q.div == 16'(OSC_DIV - 1)); // RL3
    end

    // Next-state logic for keypad, memory and outpulsing
    always_comb
    begin
        st_d = st_q;
        // Tick divider held at zero while stopped
        if (!osc_run || tick)
            st_d.div = 16'h0000;
        else
            st_d.div = st_q.div + 16'h0001;

        // Keypad side
        if (hook_in)
        begin
            // Key lines held high, nothing accepted
            st_d.kst = K_OFF; // RL8
            st_d.row_o = 4'hf;
            st_d.row_oe = 4'hf;
            st_d.col_o = 3'h7;
            st_d.col_oe = 3'h7;
            st_d.tone = 1'b0;
            if (st_q.kst != K_OFF)
            begin
                st_d.kcnt = 11'h000;
                st_d.cleared = 1'b0;
            end
            else if (tick && st_q.dst == D_IDLE && !st_q.cleared)
            begin
                // Long enough on-hook arms a fresh session
                if (st_q.kcnt == HOOK_TICKS - 11'h001)
                begin
                    st_d.cleared = 1'b1; // RL10
                    st_d.new_sess = 1'b1;
                end
                else
                    st_d.kcnt = st_q.kcnt + 11'h001;
            end
            if (st_q.dst != D_IDLE)
                st_d.fast = 1'b1; // RL19
        end
        else
        begin
            case (st_q.kst)
                K_OFF, K_IDLE:
                begin
                    // Static strobe: rows low, columns sensed
                    st_d.kst = K_IDLE;
                    st_d.row_o = 4'h0;
                    st_d.row_oe = 4'hf;
                    st_d.col_oe = 3'h0;
                    st_d.phase = 1'b0;
                    st_d.kcnt = 11'h000;
                    st_d.last = 4'h0;
                    if (st_q.kst == K_IDLE && col_i != 3'h7)
                        st_d.kst = K_SCAN; // RL9
                end
                K_SCAN, K_HELD:
                begin
                    if (tick && !st_q.phase)
                    begin
                        // Columns seen with rows low; now drive columns
                        st_d.col_cap = ~col_i;
                        st_d.phase = 1'b1;
                        st_d.row_oe = 4'h0;
                        st_d.col_o = 3'h0;
                        st_d.col_oe = 3'h7;
                    end
                    else if (tick)
                    begin
                        // Pair complete: rows read, back to row drive
                        st_d.phase = 1'b0;
                        st_d.row_o = 4'h0;
                        st_d.row_oe = 4'hf;
                        st_d.col_oe = 3'h0;
                        if (st_q.kst == K_HELD)
                        begin
                            // Release rescans; a rolled-over key debounces
                            if (!kv)
                            begin
                                st_d.kst = K_SCAN; // RL6
                                st_d.kcnt = 11'h000;
                                st_d.last = 4'h0;
                                st_d.tone = 1'b0;
                            end
                        end
                        else if (!kv)
                            st_d.kst = K_IDLE;
                        else if (kc != st_q.last)
                        begin
                            st_d.last = kc;
                            st_d.kcnt = 11'h002;
                        end
                        else if ({1'b0, st_q.kcnt} + 12'h002 <
                                 scale(DB_TICKS, rate_select_in))
                            st_d.kcnt = st_q.kcnt + 11'h002; // RL4
                        else
                        begin
                            // Accepted: 10 ms here leaves margin to 40 ms
                            st_d.kst = K_HELD; // RL12
                            st_d.tcnt = 2'h0;
                            if (st_q.new_sess)
                            begin
                                // First key: star/hash redials, else new
                                st_d.new_sess = 1'b0;
                                st_d.rd = 6'h00;
                                if (kc <= KEY_MAXDIG)
                                begin
                                    st_d.mem[0] = kc;
                                    st_d.wcnt = 6'h01;
                                end
                            end
                            else if (kc <= KEY_MAXDIG &&
                                     st_q.wcnt < MEM_DEPTH)
                            begin
                                st_d.mem[st_q.wcnt[4:0]] = kc;
                                st_d.wcnt = st_q.wcnt + 6'h01;
                            end
                        end
                    end
                    // Tone only while still held; a release keeps tone low
                    if (tick && st_q.kst == K_HELD && st_d.kst == K_HELD)
                    begin
                        if (st_q.tcnt == 2'h0)
                        begin
                            st_d.tone = ~st_q.tone; // RL13
                            st_d.tcnt = 2'(scale({10'h000, TONE_TICKS},
                                                 rate_select_in) - 12'h001);
                        end
                        else
                            st_d.tcnt = st_q.tcnt - 2'h1;
                    end
                end
                default:
                    st_d.kst = K_IDLE;
            endcase
        end

        // Outpulsing side
        if (tick && st_q.dst != D_IDLE && st_q.cnt != 12'h001)
            st_d.cnt = st_q.cnt - 12'h001; // RL3
        case (st_q.dst)
            D_IDLE:
            begin
                st_d.fast = 1'b0;
                if (st_q.rd != st_q.wcnt && !hook_in)
                begin
                    // Mute starts with the pre-digit pause
                    st_d.dst = D_PRE;
                    st_d.mute_oe = 1'b1; // RL17
                    st_d.cnt = scale(PAUSE_TICKS, rate_select_in); // RL14
                end
            end
            D_PRE, D_IDP:
            begin
                if (tick && st_q.cnt == 12'h001)
                begin
                    // Load next digit and open its first break
                    st_d.dig = st_q.mem[st_q.rd[4:0]];
                    st_d.plen = st_q.mem[st_q.rd[4:0]]; // RL15
                    st_d.rd = st_q.rd + 6'h01;
                    st_d.dst = D_BREAK;
                    st_d.pfast = st_d.fast;
                    st_d.pulse_oe = 1'b1; // RL18
                    st_d.cnt = brk_len(st_d.fast, rate_select_in,
                                       ratio_select_in);
                end
            end
            D_BREAK:
            begin
                if (tick && st_q.cnt == 12'h001)
                begin
                    st_d.pulse_oe = 1'b0; // RL18
                    st_d.plen = st_q.plen - 4'h1;
                    if (st_q.plen > 4'h1)
                    begin
                        st_d.dst = D_MAKE;
                        st_d.cnt = mk_len(st_q.pfast, rate_select_in,
                                          ratio_select_in);
                    end
                    else if (st_q.rd != st_q.wcnt)
                    begin
                        st_d.dst = D_IDP;
                        st_d.cnt = scale(st_d.fast ? FAST_PAUSE :
                                         PAUSE_TICKS, rate_select_in);
                    end
                    else
                    begin
                        st_d.dst = D_OVER;
                        st_d.cnt = scale(st_q.pfast ? FAST_MO : MO_TICKS,
                                         rate_select_in); // RL11
                    end
                end
            end
            D_MAKE:
            begin
                if (tick && st_q.cnt == 12'h001)
                begin
                    st_d.dst = D_BREAK;
                    st_d.pfast = st_d.fast;
                    st_d.pulse_oe = 1'b1;
                    st_d.cnt = brk_len(st_d.fast, rate_select_in,
                                       ratio_select_in); // RL1
                end
            end
            D_OVER:
            begin
                if (tick && st_q.cnt == 12'h001)
                begin
                    st_d.dst = D_IDLE;
                    st_d.mute_oe = 1'b0; // RL11
                end
            end
            default:
                st_d.dst = D_IDLE;
        endcase
    end

    // State register, synchronous reset
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            st_q <= ST_RESET;
        else
            st_q <= st_d;
    end

    // Outputs straight from the state register
    assign row_o = st_q.row_o;
    assign row_oe = st_q.row_oe;
    assign col_o = st_q.col_o;
    assign col_oe = st_q.col_oe;
    assign pulse_o = st_q.od_lo;
    assign pulse_oe = st_q.pulse_oe;
    assign mute_o = st_q.od_lo;
    assign mute_oe = st_q.mute_oe;
    assign tone_out = st_q.tone;

    // Checking helpers: ticks spent in break, overlap and debounce; breaks sent per digit
    logic [11:0] brk_n;
    logic [11:0] ovl_n;
    logic [11:0] scan_n;
    logic [3:0] pls_n;
    always_ff @(posedge core_clk)
    begin
        if (!rstn || !st_q.pulse_oe)
            brk_n <= 12'h000;
        else if (tick)
            brk_n <= brk_n + 12'h001;
        if (!rstn || st_q.dst != D_OVER)
            ovl_n <= 12'h000;
        else if (tick)
            ovl_n <= ovl_n + 12'h001;
        if (!rstn || st_q.kst != K_SCAN)
            scan_n <= 12'h000;
        else if (tick)
            scan_n <= scan_n + 12'h001;
        // The first break opens on the edge that leaves the pause
        if (!rstn)
            pls_n <= 4'h0;
        else if (st_q.dst == D_PRE || st_q.dst == D_IDP)
            pls_n <= {3'h0, st_d.pulse_oe};
        else if (st_d.pulse_oe && !st_q.pulse_oe)
            pls_n <= pls_n + 4'h1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_break_end;
        $fell(pulse_oe);
    endsequence
    sequence s_digit_end;
        $rose(st_q.dst == D_IDP) or $rose(st_q.dst == D_OVER);
    endsequence

    chk_onhook_hold: assert property (hook_in |=> // RL8
        row_oe == 4'hf && row_o == 4'hf && col_oe == 3'h7)
        else $error("key lines not held high on-hook");
    chk_break_mute: assert property (pulse_oe |-> mute_oe) // RL17
        else $error("break without mute");
    chk_break_len: assert property (s_break_end |-> // RL16
        brk_n == brk_len(st_q.pfast, rate_select_in, ratio_select_in))
        else $error("break length wrong");
    chk_mute_overlap: assert property ($fell(mute_oe) |-> // RL11
        ovl_n == scale(st_q.pfast ? FAST_MO : MO_TICKS, rate_select_in))
        else $error("mute overlap length wrong");
    chk_debounce_span: assert property ($rose(st_q.kst == K_HELD) |-> // RL4
        scan_n >= scale(DB_TICKS, rate_select_in))
        else $error("key accepted before debounce");
    chk_osc_static: assert property (st_q.kst == K_IDLE && // RL9
        st_q.dst == D_IDLE |-> st_q.div == 16'h0000)
        else $error("oscillator running while static");
    chk_digit_pulses: assert property (s_digit_end |-> // RL15
        pls_n == st_q.dig)
        else $error("pulse count differs from digit");
    chk_tone_tick: assert property ($changed(tone_out) && tone_out |-> // RL13
        $past(tick) && $past(st_q.kst == K_HELD))
        else $error("tone edge outside held key tick");

endmodule : pulse_dialer_with_redial

// File: hw/dialer_pkg.sv
/*
 * Shared constants, state encodings and the state record of the pulse
 * dialer. Assumes a 200 MHz core clock; every interval is counted in
 * ticks of an emulated 4 kHz oscillator derived from that clock.
 */
package dialer_pkg;

    // Clock and emulated oscillator
    localparam int CORE_HZ = 200_000_000;
    localparam int OSC_HZ = 4000;
    localparam int OSC_DIV_DEF = CORE_HZ / OSC_HZ;

    // Intervals at the 10 pps setting, in their own units
    localparam int DEBOUNCE_MS = 10;
    localparam int MUTE_OVERLAP_MS = 5;
    localparam int PAUSE_MS = 800;
    localparam int HOOK_CLEAR_MS = 300;
    localparam int PULSE_PERIOD_MS = 100;
    localparam int TONE_HZ = 1000;
    localparam int FAST_DIV = 100;
    localparam int MAKE34_PCT = 34;
    localparam int MAKE40_PCT = 40;

    // Interval lengths in oscillator ticks
    localparam int PERIOD_T = PULSE_PERIOD_MS * OSC_HZ / 1000;
    localparam logic [11:0] DB_TICKS = 12'(DEBOUNCE_MS * OSC_HZ / 1000);
    localparam logic [11:0] MO_TICKS = 12'(MUTE_OVERLAP_MS * OSC_HZ / 1000);
    localparam logic [11:0] PAUSE_TICKS = 12'(PAUSE_MS * OSC_HZ / 1000);
    localparam logic [10:0] HOOK_TICKS = 11'(HOOK_CLEAR_MS * OSC_HZ / 1000);
    localparam logic [11:0] MAKE34_TICKS = 12'(PERIOD_T * MAKE34_PCT / 100);
    localparam logic [11:0] BRK66_TICKS = 12'(PERIOD_T - PERIOD_T * 34 / 100);
    localparam logic [11:0] MAKE40_TICKS = 12'(PERIOD_T * MAKE40_PCT / 100);
    localparam logic [11:0] BRK60_TICKS = 12'(PERIOD_T - PERIOD_T * 40 / 100);
    localparam logic [11:0] FAST_HALF = 12'(PERIOD_T / FAST_DIV / 2);
    localparam logic [11:0] FAST_PAUSE = 12'(PAUSE_MS * OSC_HZ / 1000 / 100);
    localparam logic [11:0] FAST_MO = 12'h001;
    localparam logic [1:0] TONE_TICKS = 2'(OSC_HZ / (2 * TONE_HZ));
    localparam logic [5:0] MEM_DEPTH = 6'h20;

    // Key codes: digits carry their pulse count, zero sends ten
    localparam logic [3:0] KEY_STAR = 4'hb;
    localparam logic [3:0] KEY_HASH = 4'hc;
    localparam logic [3:0] KEY_MAXDIG = 4'ha;

    typedef enum logic [3:0] {
        K_OFF = 4'b0001, K_IDLE = 4'b0010,
        K_SCAN = 4'b0100, K_HELD = 4'b1000
    } key_st_t;

    typedef enum logic [5:0] {
        D_IDLE = 6'b000001, D_PRE = 6'b000010, D_BREAK = 6'b000100,
        D_MAKE = 6'b001000, D_IDP = 6'b010000, D_OVER = 6'b100000
    } dial_st_t;

    typedef struct packed {
        key_st_t kst;
        dial_st_t dst;
        logic [15:0] div;
        logic phase;
        logic [2:0] col_cap;
        logic [3:0] last;
        logic [10:0] kcnt;
        logic [1:0] tcnt;
        logic [11:0] cnt;
        logic [3:0] plen;
        logic [3:0] dig;
        logic [31:0][3:0] mem;
        logic [5:0] wcnt;
        logic [5:0] rd;
        logic new_sess;
        logic cleared;
        logic fast;
        logic pfast;
        logic [3:0] row_o;
        logic [3:0] row_oe;
        logic [2:0] col_o;
        logic [2:0] col_oe;
        logic pulse_oe;
        logic mute_oe;
        logic tone;
        logic od_lo;
    } dial_state_t;

    localparam dial_state_t ST_RESET = '{
        kst: K_IDLE, dst: D_IDLE, div: 16'h0000, phase: 1'b0,
        col_cap: 3'h0, last: 4'h0, kcnt: 11'h000, tcnt: 2'h0,
        cnt: 12'h000, plen: 4'h0, dig: 4'h0, mem: '0, wcnt: 6'h00,
        rd: 6'h00, new_sess: 1'b1, cleared: 1'b1, fast: 1'b0,
        pfast: 1'b0, row_o: 4'hf, row_oe: 4'hf, col_o: 3'h7,
        col_oe: 3'h7, pulse_oe: 1'b0, mute_oe: 1'b0, tone: 1'b0,
        od_lo: 1'b0
    };

endpackage : dialer_pkg

// File: hw/key_decode.sv
/*
 * Keypad decoder: turns the rows and columns seen low in one scan pair
 * into a key code. Assumes active-high "seen low" inputs, 4 rows by
 * 3 columns; purely combinational.
 */
`timescale 1ns/1ps
module key_decode
    import dialer_pkg::*;
(
    // Scan results
    input wire logic [3:0] row_lo,
    input wire logic [2:0] col_lo,
    // Decoded key
    output logic valid,
    output logic [3:0] code
);

    // Index of a one-hot vector, flag if not exactly one bit set
    function automatic logic [2:0] onehot_idx(input logic [3:0] v);
        case (v)
            4'h1: onehot_idx = 3'h0;
            4'h2: onehot_idx = 3'h1;
            4'h4: onehot_idx = 3'h2;
            4'h8: onehot_idx = 3'h3;
            default: onehot_idx = 3'h4;
        endcase
    endfunction : onehot_idx

    logic [2:0] ri; // Row index, 4 means invalid
    logic [2:0] ci; // Column index, 4 means invalid

    // Exactly one row with exactly one column is a key
    always_comb
    begin
        ri = onehot_idx(row_lo);
        ci = onehot_idx({1'b0, col_lo});
        valid = (ri != 3'h4) && (ci != 3'h4); // RL7
        code = 4'h0;
        if (ri == 3'h3)
        begin
            // Bottom row: star, zero, hash
            code = (ci == 3'h0) ? KEY_STAR :
                   (ci == 3'h1) ? KEY_MAXDIG : KEY_HASH;
        end
        else
        begin
            code = 4'(ri * 3 + ci + 1);
        end
    end

endmodule : key_decode

// File: test/keypad_model.sv
/*
 * Form-A keypad model: one closed key ties its row to its column.
 * Assumes the dialer's o/oe pairs; undriven lines sit at the pull-up.
 */
`timescale 1ns/1ps
module keypad_model
(
    // Dialer drive
    input wire logic [3:0] row_o,
    input wire logic [3:0] row_oe,
    input wire logic [2:0] col_o,
    input wire logic [2:0] col_oe,
    // Pressed key: 0 none, 1..9, 10 zero, 11 star, 12 hash
    input wire logic [3:0] key,
    // Resolved line levels
    output logic [3:0] row_i,
    output logic [2:0] col_i
);
    logic [3:0] rlo; // Rows pulled low by the dialer
    logic [2:0] clo; // Columns pulled low by the dialer
    logic [1:0] r;
    logic [1:0] c;
    logic link;

    // Wire resolution; low wins, released lines float high
    always_comb
    begin
        rlo = row_oe & ~row_o;
        clo = col_oe & ~col_o;
        r = 2'h3;
        c = 2'h1;
        if (key == 4'hb)
            c = 2'h0;
        else if (key == 4'hc)
            c = 2'h2;
        else if (key != 4'ha)
        begin
            r = 2'((key - 4'h1) / 3);
            c = 2'((key - 4'h1) % 3);
        end
        link = (key != 4'h0) && (rlo[r] || clo[c]);
        row_i = ~rlo;
        col_i = ~clo;
        if (link)
        begin
            row_i[r] = 1'b0;
            col_i[c] = 1'b0;
        end
    end
endmodule : keypad_model

// File: test/pulse_dialer_with_redial_test.sv
/*
 * Self-checking bench of the pulse dialer: timing of debounce, tone,
 * pauses, breaks, makes, mute overlap, on-hook fast dialing, redial.
 * Assumes a shortened oscillator divider of 6 core cycles per tick.
 */
`timescale 1ns/1ps
module pulse_dialer_with_redial_test;
    import dialer_pkg::*;
    localparam int DIV = 6; // Short tick keeps the run small
    logic core_clk, rstn, hook_in, rate_select_in, ratio_select_in;
    logic [3:0] row_i, row_o, row_oe, key;
    logic [2:0] col_i, col_o, col_oe;
    logic pulse_o, pulse_oe, mute_o, mute_oe, tone_out;
    int errors, checks, cyc, t0, d;
    logic [16:0] seed; // Random source

    pulse_dialer_with_redial #(.OSC_DIV(DIV)) u_pulse_dialer_with_redial (
        .core_clk(core_clk), .rstn(rstn), .hook_in(hook_in),
        .rate_select_in(rate_select_in), .ratio_select_in(ratio_select_in),
        .row_i(row_i), .row_o(row_o), .row_oe(row_oe), .col_i(col_i),
        .col_o(col_o), .col_oe(col_oe), .pulse_o(pulse_o),
        .pulse_oe(pulse_oe), .mute_o(mute_o), .mute_oe(mute_oe),
        .tone_out(tone_out));
    keypad_model u_keypad_model (.row_o(row_o), .row_oe(row_oe),
        .col_o(col_o), .col_oe(col_oe), .key(key), .row_i(row_i),
        .col_i(col_i));

    // 200 MHz clock and cycle count for durations
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;

    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr
    function automatic logic sig(input int s);
        return (s == 0) ? pulse_oe : (s == 1) ? mute_oe : tone_out;
    endfunction : sig

    task automatic final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic check(input int got, input int exp, input int tol);
        checks++;
        if (got > exp + tol || got < exp - tol)
        begin
            errors++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask : check
    // Bounded wait for a level on pulse, mute or tone
    task automatic wait_sig(input int s, input logic v, input int bound);
        int n;
        n = 0;
        while (sig(s) !== v)
        begin
            if (n == bound)
            begin
                errors++;
                $display("wrong value at %0t: %h vs %h", $time, sig(s), v);
                final_report();
            end
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask : wait_sig
    task automatic do_reset(input logic rate, input logic ratio);
        rstn = 1'b0;
        hook_in = 1'b0;
        rate_select_in = rate;
        ratio_select_in = ratio;
        repeat (12) @(posedge core_clk);
        #1 rstn = 1'b1;
    endtask : do_reset
    // Key down, debounce into mute, tone high half-period, then release
    task automatic key_in(input logic [3:0] k, input int db, input int th);
        int t;
        key = k;
        t0 = cyc;
        wait_sig(1, 1'b1, 160 * DIV);
        check(cyc - t0, db * DIV, 4 * DIV);
        t0 = cyc;
        wait_sig(2, 1'b1, 8 * DIV);
        t = cyc;
        wait_sig(2, 1'b0, 8 * DIV);
        check(cyc - t, th * DIV, DIV);
        repeat (40 * DIV) @(posedge core_clk);
        #1 key = 4'h0;
        // Tone must be silent once a scan pair sees the release
        repeat (4 * DIV) @(posedge core_clk);
        #1 checks++;
        if (tone_out !== 1'b0)
        begin
            errors++;
            $display("wrong value at %0t: %h vs %h", $time, tone_out, 1'b0);
        end
    endtask : key_in
    // Pause, every break and make, then mute overlap
    task automatic dial(input int np, input int pz, input int br,
        input int mk, input int mo);
        int t;
        wait_sig(0, 1'b1, pz * DIV + 400);
        check(cyc - t0, pz * DIV, 3 * DIV);
        for (int i = 0; i < np; i++)
        begin
            if (i > 0)
            begin
                wait_sig(0, 1'b1, mk * DIV + 99);
                check(cyc - t, mk * DIV, 2 * DIV);
            end
            t = cyc;
            wait_sig(0, 1'b0, br * DIV + 99);
            check(cyc - t, br * DIV, 2 * DIV);
            t = cyc;
        end
        wait_sig(1, 1'b0, mo * DIV + 99);
        check(cyc - t, mo * DIV, 2 * DIV);
    endtask : dial

    initial
    begin
        cyc = 0;
        errors = 0;
        checks = 0;
        key = 4'h0;
        seed = lfsr(17'h10b6b);
        d = 1 + int'(seed[1]);
        do_reset(1'b0, seed[0]);
        key_in(4'(d), 40, 2);
        dial(d, 3200, seed[0] ? 264 : 240, seed[0] ? 136 : 160, 20);
        $display("test slow rate done");
        do_reset(1'b1, 1'b0);
        key_in(4'ha, 20, 1);
        dial(10, 1600, 120, 80, 10);
        $display("test fast rate done");
        seed = lfsr(seed);
        do_reset(1'b1, seed[0]);
        key_in(4'h3, 20, 1);
        wait_sig(0, 1'b1, 1800 * DIV);
        wait_sig(0, 1'b0, 200 * DIV);
        hook_in = 1'b1;
        repeat (2)
        begin
            wait_sig(0, 1'b1, 100 * DIV);
            t0 = cyc;
            wait_sig(0, 1'b0, 4 * DIV);
            check(cyc - t0, DIV, DIV / 2);
        end
        wait_sig(1, 1'b0, 40 * DIV);
        key = 4'h5;
        repeat (100 * DIV) @(posedge core_clk);
        #1 checks++;
        if (mute_oe !== 1'b0 || (row_oe & ~row_o) !== 4'h0)
        begin
            errors++;
            $display("wrong value at %0t: %h vs %h", $time, row_o, 4'hf);
        end
        $display("test on hook done");
        // Long on-hook arms a fresh session; star then redials digit 3
        repeat (1200 * DIV) @(posedge core_clk);
        #1 key = 4'h0;
        repeat (2) @(posedge core_clk);
        #1 hook_in = 1'b0;
        // Next key pressed after the last one lifted, held well past 5 ms
        key_in(4'hb, 20, 1);
        dial(3, 1600, seed[0] ? 132 : 120, seed[0] ? 68 : 80, 10);
        $display("test redial done");
        final_report();
    end
endmodule : pulse_dialer_with_redial_test
